// ===== asdr_cfg.svh
// offsets, field positions, reset values and timing counts of the sampler
`ifndef ASDR_CFG_SVH
`define ASDR_CFG_SVH

// register byte offsets
`define ASDR_OFS_CTRL       12'h000
`define ASDR_OFS_NOMINAL    12'h004
`define ASDR_OFS_LOWER      12'h008
`define ASDR_OFS_UPPER      12'h00C
`define ASDR_OFS_DCRATE     12'h010
`define ASDR_OFS_STATUS     12'h014
`define ASDR_OFS_INTERVAL   12'h018
`define ASDR_OFS_OFFSET     12'h01C
`define ASDR_OFS_SAMPLE     12'h020

// control register fields
`define ASDR_CTRL_SRC_LSB   0
`define ASDR_CTRL_RANGE_BIT 4
`define ASDR_CTRL_MEAN_LSB  8

// reset values and limits; frequencies are in units of 0.01 Hz
`define ASDR_RST_NOMINAL    16'h1388
`define ASDR_RST_LOWER      16'h03E8
`define ASDR_RST_UPPER      16'h1F40
`define ASDR_RST_DCRATE     12'h001
`define ASDR_FREQ_MIN       16'h000A
`define ASDR_FREQ_MAX       16'h4E20
`define ASDR_DCRATE_MAX     12'h800

// timing
`define ASDR_CLK_HZ         20000000
`define ASDR_FREQ_SCALE     100
`define ASDR_SAMPLES        36
`define ASDR_LAST_SAMPLE    6'h23
`define ASDR_DC_SHIFT       11
`define ASDR_INV36          12'h71C
`define ASDR_INV36_SHIFT    16

`endif

// ===== asdr_pkg.sv
// types shared by the sampler modules
package asdr_pkg;

    typedef enum logic [2:0] {
        ASDR_SRC_AUTO = 3'h0,
        ASDR_SRC_ONE = 3'h1,
        ASDR_SRC_TWO = 3'h2,
        ASDR_SRC_THREE = 3'h3,
        ASDR_SRC_NOMINAL = 3'h4
    } asdr_src_t;

    typedef enum logic [1:0] {
        ASDR_MEAN_ONE = 2'h0,
        ASDR_MEAN_TWO = 2'h1,
        ASDR_MEAN_THREE = 2'h2
    } asdr_mean_t;

    typedef enum logic [1:0] {
        ASDR_ST_IDLE = 2'b01,
        ASDR_ST_DIV = 2'b10
    } asdr_state_t;

endpackage : asdr_pkg

// ===== asdr_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module asdr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic full_q;
    logic push;
    logic pop;
    logic [AW:0] count_d;

    assign push = in_valid && !full_q;
    assign pop = out_ready && (count_q != '0);
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = !full_q;
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
        end else begin
            if (push) wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            if (pop) rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            count_q <= count_d;
            full_q <= (count_d == (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge hclk) begin
        if (push) mem_q[wr_ptr_q] <= in_data;
    end

endmodule : asdr_fifo

// ===== asdr_div.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module asdr_div (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request
    input wire logic start,
    input wire logic [31:0] numer,
    input wire logic [19:0] denom,
    // answer
    output logic busy,
    output logic done,
    output logic [31:0] quot
);
    logic [31:0] quot_q;
    logic [32:0] rem_q;
    logic [19:0] den_q;
    logic [5:0] bit_q;
    logic busy_q;
    logic done_q;
    logic [32:0] trial;
    logic fits;

    assign trial = {rem_q[31:0], quot_q[31]};
    assign fits = trial >= {13'h0000, den_q};
    assign busy = busy_q;
    assign done = done_q;
    assign quot = quot_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quot_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            bit_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                quot_q <= numer;
                rem_q <= '0;
                den_q <= denom;
                bit_q <= 6'h20;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= fits ? trial - {13'h0000, den_q} : trial;
                quot_q <= {quot_q[30:0], fits};
                bit_q <= bit_q - 6'h01;
                if (bit_q == 6'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule : asdr_div

// ===== asdr_sampler.sv
// adaptive sample timing, frequency source choice and current dc removal
`timescale 1ns/1ps
`include "asdr_cfg.svh"

module asdr_sampler
    import asdr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // measured frequencies of the voltage inputs, 0.01 Hz units
    input wire logic [15:0] freq_input_one,
    input wire logic [15:0] freq_input_two,
    input wire logic [15:0] freq_input_three,
    // current samples from the converter
    input wire logic cur_valid,
    input wire logic signed [15:0] cur_data,
    output logic cur_ready,
    // sampling and range controls
    output logic sample_strobe,
    output logic [5:0] sample_index,
    output logic range_third_hi,
    output logic range_ground_hi,
    output logic [1:0] mean_voltage_source_select
);
    localparam logic [31:0] NUMER = 32'(`ASDR_CLK_HZ * `ASDR_FREQ_SCALE);

    // ---------------- functions ----------------
    function automatic logic [15:0] pick_freq(
        input logic [2:0] src,
        input logic [15:0] f1,
        input logic [15:0] f2,
        input logic [15:0] f3,
        input logic [15:0] nom,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        logic [15:0] m;
        m = 16'h0000;
        case (src)
            ASDR_SRC_ONE: m = f1;
            ASDR_SRC_TWO: m = f2;
            ASDR_SRC_THREE: m = f3;
            ASDR_SRC_AUTO: m = (f1 != 16'h0000) ? f1 : (f2 != 16'h0000) ? f2 : f3;
            default: m = 16'h0000;
        endcase
        if (m == 16'h0000 || m < lo || m > hi) begin
            return nom;
        end
        return m;
    endfunction : pick_freq

    function automatic logic [15:0] clamp_freq(input logic [15:0] v);
        if (v < `ASDR_FREQ_MIN) return `ASDR_FREQ_MIN;
        if (v > `ASDR_FREQ_MAX) return `ASDR_FREQ_MAX;
        return v;
    endfunction : clamp_freq

    function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sh07FFF) return 16'sh7FFF;
        if (v < -18'sh08000) return -16'sh8000;
        return v[15:0];
    endfunction : sat16

    // ---------------- registers ----------------
    logic [2:0] src_q;
    logic range_q;
    logic [1:0] mean_q;
    logic [15:0] nominal_q;
    logic [15:0] lower_q;
    logic [15:0] upper_q;
    logic [11:0] dcrate_q;
    logic [31:0] interval_q;
    logic [31:0] tick_q;
    logic [5:0] index_q;
    logic strobe_q;
    logic [15:0] divided_freq_q;
    logic signed [15:0] offset_q;
    logic signed [23:0] sum_q;
    asdr_state_t state_q;

    // ahb pipeline
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic range_third_q;
    logic range_ground_q;
    logic [1:0] mean_out_q;

    // ---------------- bus decode ----------------
    logic addr_phase;
    logic rd_req;
    logic wr_req;
    logic word_ok;
    logic hit_ctrl;
    logic hit_nom;
    logic hit_low;
    logic hit_up;
    logic hit_rate;
    logic hit_stat;
    logic hit_int;
    logic hit_ofs;
    logic hit_smp;
    logic [31:0] rd_data;
    logic w_ctrl;
    logic w_nom;
    logic w_low;
    logic w_up;
    logic w_rate;

    assign addr_phase = hsel && htrans[1] && hready;
    assign word_ok = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
    assign rd_req = addr_phase && !hwrite && word_ok;
    assign wr_req = addr_phase && hwrite && word_ok;
    assign hit_ctrl = (haddr == `ASDR_OFS_CTRL);
    assign hit_nom = (haddr == `ASDR_OFS_NOMINAL);
    assign hit_low = (haddr == `ASDR_OFS_LOWER);
    assign hit_up = (haddr == `ASDR_OFS_UPPER);
    assign hit_rate = (haddr == `ASDR_OFS_DCRATE);
    assign hit_stat = (haddr == `ASDR_OFS_STATUS);
    assign hit_int = (haddr == `ASDR_OFS_INTERVAL);
    assign hit_ofs = (haddr == `ASDR_OFS_OFFSET);
    assign hit_smp = (haddr == `ASDR_OFS_SAMPLE);

    // fifo draining side
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic fifo_pop;
    assign fifo_pop = rd_req && hit_smp;

    // status word
    logic [15:0] sel_freq;
    logic [31:0] status_word;
    assign status_word = {6'h00, index_q, 3'h0, fifo_out_valid, sel_freq};

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_data[`ASDR_CTRL_SRC_LSB +: 3] = src_q;
            rd_data[`ASDR_CTRL_RANGE_BIT] = range_q;
            rd_data[`ASDR_CTRL_MEAN_LSB +: 2] = mean_q;
        end else if (hit_nom) begin
            rd_data = {16'h0000, nominal_q};
        end else if (hit_low) begin
            rd_data = {16'h0000, lower_q};
        end else if (hit_up) begin
            rd_data = {16'h0000, upper_q};
        end else if (hit_rate) begin
            rd_data = {20'h00000, dcrate_q};
        end else if (hit_stat) begin
            rd_data = status_word;
        end else if (hit_int) begin
            rd_data = interval_q;
        end else if (hit_ofs) begin
            rd_data = {{16{offset_q[15]}}, offset_q};
        end else if (hit_smp) begin
            // bit 16 tells whether the word held a real sample
            rd_data = {15'h0000, fifo_out_valid, fifo_out_data};
        end
    end

    assign w_ctrl = wr_pend_q && (wr_addr_q == `ASDR_OFS_CTRL);
    assign w_nom = wr_pend_q && (wr_addr_q == `ASDR_OFS_NOMINAL);
    assign w_low = wr_pend_q && (wr_addr_q == `ASDR_OFS_LOWER);
    assign w_up = wr_pend_q && (wr_addr_q == `ASDR_OFS_UPPER);
    assign w_rate = wr_pend_q && (wr_addr_q == `ASDR_OFS_DCRATE);

    // out-of-range settings are replaced instead of refused: rate and frequencies clamp, source and mean fall back to auto and one
    logic [11:0] rate_wr;
    logic [2:0] src_wr;
    logic [1:0] mean_wr;
    assign rate_wr = (hwdata[31:11] != 21'h000000) ? `ASDR_DCRATE_MAX :
                     (hwdata[11:0] == 12'h000) ? 12'h001 : hwdata[11:0];
    assign src_wr = (hwdata[`ASDR_CTRL_SRC_LSB +: 3] > ASDR_SRC_NOMINAL) ? ASDR_SRC_AUTO :
                    hwdata[`ASDR_CTRL_SRC_LSB +: 3];
    assign mean_wr = (hwdata[`ASDR_CTRL_MEAN_LSB +: 2] == 2'h3) ? ASDR_MEAN_ONE :
                     hwdata[`ASDR_CTRL_MEAN_LSB +: 2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            wr_pend_q <= wr_req;
            wr_addr_q <= haddr;
            if (rd_req) hrdata_q <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= ASDR_SRC_AUTO;
            range_q <= 1'b1;
            mean_q <= ASDR_MEAN_ONE;
            nominal_q <= `ASDR_RST_NOMINAL;
            lower_q <= `ASDR_RST_LOWER;
            upper_q <= `ASDR_RST_UPPER;
            dcrate_q <= `ASDR_RST_DCRATE;
        end else begin
            if (w_ctrl) begin
                src_q <= src_wr;
                range_q <= hwdata[`ASDR_CTRL_RANGE_BIT];
                mean_q <= mean_wr;
            end
            if (w_nom) nominal_q <= clamp_freq(hwdata[15:0]);
            if (w_low) lower_q <= clamp_freq(hwdata[15:0]);
            if (w_up) upper_q <= clamp_freq(hwdata[15:0]);
            if (w_rate) dcrate_q <= rate_wr;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // ---------------- frequency choice and interval ----------------
    assign sel_freq = pick_freq(src_q, freq_input_one, freq_input_two, freq_input_three,
                                nominal_q, lower_q, upper_q);

    logic div_start;
    logic div_busy;
    logic div_done;
    logic [31:0] div_quot;
    logic [19:0] div_den;
    logic freq_changed;

    // denominator is frequency times samples per cycle
    assign div_den = 20'(sel_freq) * 20'(`ASDR_SAMPLES);
    assign freq_changed = (sel_freq != divided_freq_q);
    assign div_start = (state_q == ASDR_ST_IDLE) && freq_changed;

    asdr_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(div_start),
        .numer(NUMER),
        .denom(div_den),
        .busy(div_busy),
        .done(div_done),
        .quot(div_quot)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ASDR_ST_IDLE;
            divided_freq_q <= 16'h0000;
            interval_q <= 32'h0000_0001;
        end else begin
            case (state_q)
                ASDR_ST_IDLE: begin
                    if (div_start) begin
                        state_q <= ASDR_ST_DIV;
                        divided_freq_q <= sel_freq;
                    end
                end
                ASDR_ST_DIV: begin
                    if (div_done) begin
                        state_q <= ASDR_ST_IDLE;
                        interval_q <= (div_quot == 32'h0000_0000) ? 32'h0000_0001 : div_quot;
                    end
                end
                default: state_q <= ASDR_ST_IDLE;
            endcase
        end
    end

    // ---------------- sample timing ----------------
    logic tick_wrap;
    logic cycle_end;
    assign tick_wrap = (tick_q >= interval_q - 32'h0000_0001);
    assign cycle_end = tick_wrap && (index_q == `ASDR_LAST_SAMPLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 32'h0000_0000;
            index_q <= 6'h00;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= tick_wrap;
            if (tick_wrap) begin
                tick_q <= 32'h0000_0000;
                index_q <= cycle_end ? 6'h00 : index_q + 6'h01;
            end else begin
                tick_q <= tick_q + 32'h0000_0001;
            end
        end
    end

    // ---------------- dc removal ----------------
    logic fifo_in_ready;
    logic take;
    logic signed [17:0] resid_wide;
    logic signed [15:0] resid;
    logic signed [23:0] sum_next;
    logic signed [36:0] scaled;
    logic signed [49:0] mean_corr;
    logic signed [15:0] offset_next;

    assign take = cur_valid && fifo_in_ready;
    assign resid_wide = 18'(cur_data) - 18'(offset_q);
    assign resid = sat16(resid_wide);
    assign sum_next = sum_q + (take ? 24'(resid) : 24'sh000000);
    // residual sum times rate/2048: full step at 2048, 1/2048 step at 1
    assign scaled = (37'(sum_next) * $signed({25'h0000000, dcrate_q})) >>> `ASDR_DC_SHIFT;
    // divide by 36 via a fixed reciprocal; tiny gain error is harmless
    assign mean_corr = (50'(scaled) * $signed({38'h0, `ASDR_INV36})) >>> `ASDR_INV36_SHIFT;
    assign offset_next = sat16(18'(offset_q) + mean_corr[17:0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sum_q <= 24'sh000000;
            offset_q <= 16'sh0000;
        end else if (cycle_end) begin
            sum_q <= 24'sh000000;
            offset_q <= offset_next;
        end else begin
            sum_q <= sum_next;
        end
    end

    asdr_fifo #(
        .WIDTH(16),
        .DEPTH(4)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(cur_valid),
        .in_ready(fifo_in_ready),
        .in_data(resid),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    assign cur_ready = fifo_in_ready;

    // ---------------- range and mean outputs ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            range_third_q <= 1'b1;
            range_ground_q <= 1'b1;
            mean_out_q <= ASDR_MEAN_ONE;
        end else begin
            range_third_q <= range_q;
            range_ground_q <= range_q;
            mean_out_q <= mean_q;
        end
    end

    assign sample_strobe = strobe_q;
    assign sample_index = index_q;
    assign range_third_hi = range_third_q;
    assign range_ground_hi = range_ground_q;
    assign mean_voltage_source_select = mean_out_q;

endmodule : asdr_sampler

// ===== asdr_checker.sv
// port checker for the sampler, bound into asdr_sampler
`timescale 1ns/1ps
`include "asdr_cfg.svh"
module asdr_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // sampling and range
    input wire logic [5:0] sample_index,
    input wire logic range_third_hi,
    input wire logic range_ground_hi,
    input wire logic [1:0] mean_voltage_source_select
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_addr(logic [11:0] a, logic w);
        hsel && htrans == 2'b10 && hwrite == w && haddr == a && hsize == 3'h2 && hready;
    endsequence
    // address phase then its data phase
    sequence s_ctrl_wr;
        s_addr(`ASDR_OFS_CTRL, 1'b1) ##1 hready;
    endsequence

    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_ready_held: assert property ($past(hresetn) |-> hreadyout)
        else $error("wait state inserted");
    a_range_pair: assert property (range_third_hi == range_ground_hi)
        else $error("range outputs differ");
    a_range_write: assert property (s_ctrl_wr |=> ##1 range_third_hi == $past(hwdata[4], 2))
        else $error("range not taken from control write");
    a_mean_write: assert property (s_ctrl_wr |=> ##1 mean_voltage_source_select ==
        (($past(hwdata[9:8], 2) == 2'h3) ? 2'h0 : $past(hwdata[9:8], 2)))
        else $error("mean source not taken from control write");
    a_mean_legal: assert property (mean_voltage_source_select != 2'h3)
        else $error("mean source out of range");
    a_index_bound: assert property (sample_index <= `ASDR_LAST_SAMPLE)
        else $error("sample index beyond last");
    a_index_step: assert property ($changed(sample_index) |-> sample_index ==
        (($past(sample_index) == `ASDR_LAST_SAMPLE) ? 6'h00 : $past(sample_index) + 6'h01))
        else $error("sample index skipped");
    a_unmapped_zero: assert property (s_addr(12'h100, 1'b0) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : asdr_checker

bind asdr_sampler asdr_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_index(sample_index), .range_third_hi(range_third_hi),
    .range_ground_hi(range_ground_hi), .mean_voltage_source_select(mean_voltage_source_select));

// ===== asdr_analog_model.sv
// behavioural front end: measured frequencies and current sample stream
`timescale 1ns/1ps
module asdr_analog_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench controls
    input wire logic [15:0] f1_set,
    input wire logic [15:0] f2_set,
    input wire logic [15:0] f3_set,
    input wire logic src_en,
    // towards the sampler
    output logic [15:0] freq_input_one,
    output logic [15:0] freq_input_two,
    output logic [15:0] freq_input_three,
    output logic cur_valid,
    output logic signed [15:0] cur_data,
    input wire logic cur_ready
);
    logic [15:0] val_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_input_one <= 16'h0000;
            freq_input_two <= 16'h0000;
            freq_input_three <= 16'h0000;
            cur_valid <= 1'b0;
            cur_data <= 16'sh5A5A;
            val_q <= 16'h0100;
        end else begin
            freq_input_one <= f1_set;
            freq_input_two <= f2_set;
            freq_input_three <= f3_set;
            // an offered sample is held until taken; idle data toggles so it is never trusted
            if (cur_valid && cur_ready) begin
                val_q <= val_q + 16'h0001;
                cur_valid <= src_en;
                cur_data <= src_en ? $signed(val_q + 16'h0001) : ~cur_data;
            end else if (!cur_valid) begin
                cur_valid <= src_en;
                cur_data <= src_en ? $signed(val_q) : ~cur_data;
            end
        end
    end
endmodule : asdr_analog_model

// ===== tb_adaptive_sampler_dc_removal.sv
// self-checking bench for the adaptive sampler
`timescale 1ns/1ps
`include "asdr_cfg.svh"
module tb_adaptive_sampler_dc_removal import asdr_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic src_en = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0, rd;
    logic [15:0] f1_set = 16'h0000, f2_set = 16'h0000, f3_set = 16'h0000;
    logic [15:0] f1, f2, f3;
    logic signed [15:0] cur_data;
    logic hreadyout, hresp, cur_valid, cur_ready, sample_strobe, rng3, rngg;
    logic [31:0] hrdata;
    logic [5:0] sample_index;
    logic [1:0] mean_sel;
    int fails = 0, compares = 0, n;

    always #25 hclk = ~hclk;

    asdr_sampler uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .freq_input_one(f1),
        .freq_input_two(f2), .freq_input_three(f3), .cur_valid(cur_valid),
        .cur_data(cur_data), .cur_ready(cur_ready), .sample_strobe(sample_strobe),
        .sample_index(sample_index), .range_third_hi(rng3), .range_ground_hi(rngg),
        .mean_voltage_source_select(mean_sel));
    asdr_analog_model u_model (.hclk(hclk), .hresetn(hresetn), .f1_set(f1_set),
        .f2_set(f2_set), .f3_set(f3_set), .src_en(src_en), .freq_input_one(f1),
        .freq_input_two(f2), .freq_input_three(f3), .cur_valid(cur_valid),
        .cur_data(cur_data), .cur_ready(cur_ready));

    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // entered just after a rising edge; returns at the edge that ends the data phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task automatic wrrd(input logic [11:0] a, input logic [31:0] w, input logic [31:0] e);
        xfer(1'b1, a, w);
        rdchk(a, e);
    endtask : wrrd

    task automatic fcase(input asdr_src_t s, input logic [15:0] a, input logic [15:0] b,
                         input logic [15:0] c, input logic [15:0] e);
        f1_set <= a;
        f2_set <= b;
        f3_set <= c;
        xfer(1'b1, `ASDR_OFS_CTRL, 32'h10 | 32'(s));
        // a stale choice can cost one more 34-cycle divide
        repeat (70) @(posedge hclk);
        xfer(1'b0, `ASDR_OFS_STATUS, 32'h0);
        chk({16'h0, rd[15:0]}, {16'h0, e});
        rdchk(`ASDR_OFS_INTERVAL, 32'(2000000000 / (36 * int'(e))));
    endtask : fcase

    task automatic gap(output int g);
        g = 0;
        do @(negedge hclk); while (sample_strobe !== 1'b1);
        do begin
            @(negedge hclk);
            g++;
        end while (sample_strobe !== 1'b1);
        @(posedge hclk);
    endtask : gap

    initial begin
        repeat (80000) @(posedge hclk);
        fails++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdchk(`ASDR_OFS_CTRL, 32'h10);
        rdchk(`ASDR_OFS_NOMINAL, {16'h0, `ASDR_RST_NOMINAL});
        rdchk(`ASDR_OFS_LOWER, {16'h0, `ASDR_RST_LOWER});
        rdchk(`ASDR_OFS_UPPER, {16'h0, `ASDR_RST_UPPER});
        rdchk(`ASDR_OFS_DCRATE, {20'h0, `ASDR_RST_DCRATE});
        wrrd(12'h100, 32'hFFFF_FFFF, 32'h0);
        chk({30'h0, rng3, rngg}, 32'h3);
        $display("reset values test done");

        // fill the buffer until refused, then drain while the source stalls
        src_en <= 1'b1;
        for (n = 0; n < 20 && cur_ready !== 1'b0; n++) @(negedge hclk);
        chk({31'h0, cur_ready}, 32'h0);
        @(posedge hclk);
        src_en <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rdchk(`ASDR_OFS_SAMPLE, 32'h0001_0100 + 32'(i));
        end
        repeat (4) @(posedge hclk);
        xfer(1'b0, `ASDR_OFS_SAMPLE, 32'h0);
        chk({31'h0, rd[16]}, 32'h0);
        $display("sample buffer test done");

        fcase(ASDR_SRC_AUTO, 16'h1770, 16'h0FA0, 16'h0000, 16'h1770);
        fcase(ASDR_SRC_AUTO, 16'h0000, 16'h0FA0, 16'h157C, 16'h0FA0);
        fcase(ASDR_SRC_AUTO, 16'h0000, 16'h0000, 16'h157C, 16'h157C);
        fcase(ASDR_SRC_AUTO, 16'h0000, 16'h0000, 16'h0000, 16'h1388);
        fcase(ASDR_SRC_ONE, 16'h0000, 16'h0FA0, 16'h0000, 16'h1388);
        fcase(ASDR_SRC_TWO, 16'h1770, 16'h1194, 16'h0000, 16'h1194);
        fcase(ASDR_SRC_THREE, 16'h1770, 16'h0000, 16'h1B58, 16'h1B58);
        fcase(ASDR_SRC_NOMINAL, 16'h1770, 16'h1194, 16'h1B58, 16'h1388);
        fcase(ASDR_SRC_ONE, 16'h01F4, 16'h0000, 16'h0000, 16'h1388);
        fcase(ASDR_SRC_ONE, 16'h03E8, 16'h0000, 16'h0000, 16'h03E8);
        fcase(ASDR_SRC_ONE, 16'h2328, 16'h0000, 16'h0000, 16'h1388);
        fcase(ASDR_SRC_ONE, 16'h1F40, 16'h0000, 16'h0000, 16'h1F40);
        $display("frequency source test done");

        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, `ASDR_OFS_CTRL, 32'h10 | (32'(m) << `ASDR_CTRL_MEAN_LSB));
            repeat (2) @(negedge hclk);
            chk({30'h0, mean_sel}, (m == 3) ? 32'h0 : 32'(m));
            @(posedge hclk);
        end
        xfer(1'b1, `ASDR_OFS_CTRL, 32'h0);
        repeat (2) @(negedge hclk);
        chk({30'h0, rng3, rngg}, 32'h0);
        @(posedge hclk);
        wrrd(`ASDR_OFS_DCRATE, 32'h0, 32'h1);
        wrrd(`ASDR_OFS_DCRATE, 32'h1, 32'h1);
        wrrd(`ASDR_OFS_DCRATE, 32'h800, 32'h800);
        wrrd(`ASDR_OFS_DCRATE, 32'hFFF, 32'h800);
        $display("control and rate test done");

        // highest frequency keeps a gap short; the new interval is in place before the first gap ends
        xfer(1'b1, `ASDR_OFS_NOMINAL, {16'h0, `ASDR_FREQ_MAX});
        xfer(1'b1, `ASDR_OFS_CTRL, 32'h14);
        gap(n);
        gap(n);
        gap(n);
        chk(32'(n), 32'(2000000000 / (36 * 20000)));
        gap(n);
        chk(32'(n), 32'(2000000000 / (36 * 20000)));
        $display("sample spacing test done");
        stop_test();
    end
endmodule : tb_adaptive_sampler_dc_removal
